// *** verilog/csp_clock_ctrl.sv ***
// Start-up sequencer, clock source select, system prescaler and trim register
// ------------------------------------------------------------------
// What this block does
// - Internal reset asserts on any reset source, holds until start-up ends.
// - First step counts 64 ms reset delay on 128 kHz oscillator.
// - Supply level is never watched; full delay always counted.
// - Second step counts 6 calibrated oscillator cycles.
// - Last step loads configuration over 21 system clock cycles.
// - After reset, calibrated oscillator is main clock, divided by eight.
// - With brown-out detection enabled, power-up delay becomes 128 ms.
// - Power-down wake skips reset delay, counts 6 main clock cycles.
// - Brown-out detector off in power-down or standby extends wake-up to about 60 us.
// - Idle, noise-reduction and standby wake add no oscillator delay.
// - Source select: 00 calibrated, 01 128 kHz, 10 external, 11 reserved.
// - Source changes at run time switch without glitches.
// - Divider code n divides by two to the n, codes above eight reserved.
// - Divider code resets to three, dividing by eight.
// - Every chip reset loads the factory trim; software may overwrite.
// - Trim 0x00 gives lowest frequency, 0xFF the highest.
// - Divider changes are glitch free, never faster than old or new.
// ------------------------------------------------------------------
module csp_clock_ctrl
  import csp_pkg::*;
#(
  parameter int          RST_TICKS     = RST_DELAY_TICKS,
  parameter int          RST_BOD_TICKS = csp_pkg::RST_BOD_TICKS,
  parameter logic [7:0]  UNLOCK_SIG    = UNLOCK_SIG_DFLT
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Oscillator ticks, reset sources and options
  input  wire logic                  rcOscTick,
  input  wire logic                  lpOscTick,
  input  wire logic                  extClkTick,
  input  wire logic                  resetSrc,
  input  wire logic                  bodEnable,
  input  wire logic [TRIM_W-1:0]     factoryTrim,
  input  wire csp_sleep_t            sleepCtl,
  // Clock and reset outputs
  output logic                       internalRst_n,
  output logic                       mainClkEn,
  output logic                       sysClkEn,
  output logic      [TRIM_W-1:0]     oscTrim,
  output logic      [SEL_W-1:0]      activeSource
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csp_state_t          state_q;
  csp_state_t          state_d;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    delayTarget;
  logic                powerUp_q;
  csp_sleep_mode_t     slpMode_q;
  logic                slpBodOff_q;
  logic [SEL_W-1:0]    selReg_q;
  logic [SEL_W-1:0]    activeSel_q;
  logic [DIV_W-1:0]    divReg_q;
  logic [DIV_W-1:0]    activeDiv_q;
  logic [7:0]          divCnt_q;
  logic [TRIM_W-1:0]   trim_q;
  logic [2:0]          unlockCnt_q;
  logic [2:0]          srcTicks;
  logic                mainTick;
  logic                sysTick;
  logic                stepTick;
  logic                stepDone;
  logic                inReset;
  logic                apbDone;
  logic                apbWrite;
  logic [5:0]          wrIdx;
  logic                protWrite;

  // Word index of an aligned address, all ones when misaligned
  function automatic logic [5:0] regIndex(input logic [APB_ADDR_W-1:0] addr);
    regIndex = (addr[1:0] == 2'h0) ? addr[7:2] : 6'h3F;
  endfunction

  // Whether an index names a mapped register
  function automatic logic isMapped(input logic [5:0] idx);
    isMapped = (idx == IDX_SYS_CLOCK_DIVIDER_REG) || (idx == IDX_MAIN_CLOCK_SOURCE_REG) ||
               (idx == IDX_OSC_TRIM_REG) || (idx == IDX_STARTUP_STATUS_REG) ||
               (idx == IDX_CONFIG_CHANGE_PROTECT);
  endfunction

  assign inReset   = (state_q == ST_HOLD) || (state_q == ST_DELAY) || (state_q == ST_OSC);
  assign apbDone   = psel && penable && pready;
  assign apbWrite  = apbDone && pwrite;
  assign wrIdx     = regIndex(paddr);
  assign protWrite = apbWrite && (unlockCnt_q != 3'h0);

  // ----------------------------------------------------------------
  // Main clock source select
  // ----------------------------------------------------------------
  assign srcTicks = {extClkTick, lpOscTick, rcOscTick};
  assign mainTick = srcTicks[activeSel_q];

  // The new source takes over only on one of its own ticks, so no short pulse appears
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeSel_q <= SEL_RC8M;
    end else if (inReset) begin
      activeSel_q <= SEL_RC8M;
    end else if (selReg_q != activeSel_q && srcTicks[selReg_q]) begin
      activeSel_q <= selReg_q;
    end
  end

  // ----------------------------------------------------------------
  // System clock prescaler
  // ----------------------------------------------------------------
  // A new division takes effect only at the end of a full period, so no period is shorter than old or new
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q    <= 8'h00;
      activeDiv_q <= DIV_RESET;
    end else if (inReset) begin
      divCnt_q    <= 8'h00;
      activeDiv_q <= DIV_RESET;
    end else if (mainTick) begin
      if (sysTick) begin
        divCnt_q    <= 8'h00;
        activeDiv_q <= divReg_q;
      end else begin
        divCnt_q    <= divCnt_q + 8'h01;
      end
    end
  end

  assign sysTick = mainTick && (divCnt_q == 8'((9'h001 << activeDiv_q) - 9'h001));

  // ----------------------------------------------------------------
  // Start-up and wake sequencer
  // ----------------------------------------------------------------
  // Supply level plays no part: only the tick count ends the delay
  assign delayTarget = (powerUp_q && bodEnable) ? CNT_W'(RST_BOD_TICKS) : CNT_W'(RST_TICKS);

  always_comb begin
    case (state_q)
      ST_DELAY:    stepTick = lpOscTick;
      ST_OSC:      stepTick = rcOscTick;
      ST_CONFIG:   stepTick = sysTick;
      ST_WAKE_OSC: stepTick = mainTick;
      ST_WAKE_BOD: stepTick = 1'b1;
      default:     stepTick = 1'b0;
    endcase
  end

  always_comb begin
    case (state_q)
      ST_DELAY:    stepDone = stepTick && (cnt_q == delayTarget - CNT_W'(1));
      ST_OSC:      stepDone = stepTick && (cnt_q == CNT_W'(OSC_START_CYC - 1));
      ST_CONFIG:   stepDone = stepTick && (cnt_q == CNT_W'(CONFIG_CYC - 1));
      ST_WAKE_OSC: stepDone = stepTick && (cnt_q == CNT_W'(OSC_START_CYC - 1));
      ST_WAKE_BOD: stepDone = stepTick && (cnt_q == CNT_W'(BOD_WAKE_CYC - 1));
      default:     stepDone = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:     state_d = ST_DELAY;
      ST_DELAY:    if (stepDone) state_d = ST_OSC;
      ST_OSC:      if (stepDone) state_d = ST_CONFIG;
      ST_CONFIG:   if (stepDone) state_d = ST_RUN;
      ST_RUN:      if (sleepCtl.enter) state_d = ST_SLEEP;
      ST_SLEEP: begin
        if (sleepCtl.wake) begin
          if (slpMode_q == SLP_POWER_DOWN) begin
            state_d = ST_WAKE_OSC;
          end else if (slpMode_q == SLP_STANDBY && slpBodOff_q) begin
            state_d = ST_WAKE_BOD;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_WAKE_OSC: if (stepDone) state_d = slpBodOff_q ? ST_WAKE_BOD : ST_RUN;
      ST_WAKE_BOD: if (stepDone) state_d = ST_RUN;
      default:     state_d = ST_HOLD;
    endcase
    if (resetSrc) begin
      state_d = ST_HOLD;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (stepTick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Power-up flag selects the longer brown-out delay only for the first start
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerUp_q <= 1'b1;
    end else if (state_q == ST_DELAY && stepDone) begin
      powerUp_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slpMode_q   <= SLP_IDLE;
      slpBodOff_q <= 1'b0;
    end else if (state_q == ST_RUN && sleepCtl.enter) begin
      slpMode_q   <= sleepCtl.mode;
      slpBodOff_q <= sleepCtl.bodOff &&
                     (sleepCtl.mode == SLP_POWER_DOWN || sleepCtl.mode == SLP_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Unlock window counted in system clock cycles; a protected write uses it up
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      unlockCnt_q <= 3'h0;
    end else if (apbWrite && wrIdx == IDX_CONFIG_CHANGE_PROTECT && pwdata[7:0] == UNLOCK_SIG) begin
      unlockCnt_q <= UNLOCK_WINDOW;
    end else if (protWrite && (wrIdx == IDX_MAIN_CLOCK_SOURCE_REG || wrIdx == IDX_SYS_CLOCK_DIVIDER_REG)) begin
      unlockCnt_q <= 3'h0;
    end else if (sysTick && unlockCnt_q != 3'h0) begin
      unlockCnt_q <= unlockCnt_q - 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      selReg_q <= SEL_RC8M;
    end else if (inReset) begin
      selReg_q <= SEL_RC8M;
    end else if (protWrite && wrIdx == IDX_MAIN_CLOCK_SOURCE_REG && pwdata[1:0] != SEL_RESERVED) begin
      selReg_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divReg_q <= DIV_RESET;
    end else if (inReset) begin
      divReg_q <= DIV_RESET;
    end else if (protWrite && wrIdx == IDX_SYS_CLOCK_DIVIDER_REG && pwdata[3:0] <= DIV_MAX_CODE) begin
      divReg_q <= pwdata[3:0];
    end
  end

  // Factory trim is taken as configuration loading starts
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_q <= TRIM_RESET;
    end else if (state_q == ST_OSC && state_d == ST_CONFIG) begin
      trim_q <= factoryTrim;
    end else if (apbWrite && wrIdx == IDX_OSC_TRIM_REG) begin
      trim_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !isMapped(regIndex(paddr));
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        case (regIndex(paddr))
          IDX_SYS_CLOCK_DIVIDER_REG: prdata <= {28'h000_0000, divReg_q};
          IDX_MAIN_CLOCK_SOURCE_REG: prdata <= {30'h0000_0000, selReg_q};
          IDX_OSC_TRIM_REG:          prdata <= {24'h00_0000, trim_q};
          IDX_STARTUP_STATUS_REG:    prdata <= {22'h00_0000, state_q, !internalRst_n,
                                                activeSel_q, activeDiv_q};
          IDX_CONFIG_CHANGE_PROTECT: prdata <= {31'h0000_0000, unlockCnt_q != 3'h0};
          default:                   prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      internalRst_n <= 1'b0;
      mainClkEn     <= 1'b0;
      sysClkEn      <= 1'b0;
      oscTrim       <= TRIM_RESET;
      activeSource  <= SEL_RC8M;
    end else begin
      internalRst_n <= (state_d == ST_RUN || state_d == ST_SLEEP ||
                        state_d == ST_WAKE_OSC || state_d == ST_WAKE_BOD);
      mainClkEn     <= mainTick && (state_q == ST_CONFIG || state_q == ST_RUN);
      sysClkEn      <= sysTick && (state_q == ST_CONFIG || state_q == ST_RUN);
      oscTrim       <= trim_q;
      activeSource  <= activeSel_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] ticksSeen_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ticksSeen_q <= '0;
    end else if (state_d != state_q) begin
      ticksSeen_q <= '0;
    end else if (stepTick) begin
      ticksSeen_q <= ticksSeen_q + CNT_W'(1);
    end
  end

  sequence sUnlockWrite;
    apbWrite && wrIdx == IDX_CONFIG_CHANGE_PROTECT && pwdata[7:0] == UNLOCK_SIG;
  endsequence

  sequence sLockedWrite;
    apbWrite && unlockCnt_q == 3'h0 &&
    (wrIdx == IDX_MAIN_CLOCK_SOURCE_REG || wrIdx == IDX_SYS_CLOCK_DIVIDER_REG);
  endsequence

  chk_reset_assert: assert property (@(posedge ref_clk) disable iff (!reset_n)
    resetSrc |=> !internalRst_n)
    else $error("internal reset not asserted on reset source");

  chk_release_config: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(internalRst_n) |-> $past(state_q) == ST_CONFIG && $past(ticksSeen_q) == CNT_W'(CONFIG_CYC - 1))
    else $error("internal reset released before configuration load finished");

  chk_delay_length: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == ST_DELAY && state_d == ST_OSC) |-> ticksSeen_q + CNT_W'(1) == delayTarget)
    else $error("reset delay length wrong");

  chk_osc_six: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ((state_q == ST_OSC || state_q == ST_WAKE_OSC) && state_d != state_q && !resetSrc)
      |-> ticksSeen_q == CNT_W'(OSC_START_CYC - 1))
    else $error("oscillator start-up count wrong");

  chk_bod_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == ST_WAKE_BOD && state_d == ST_RUN) |-> ticksSeen_q == CNT_W'(BOD_WAKE_CYC - 1))
    else $error("brown-out wake delay wrong");

  chk_quick_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == ST_SLEEP && sleepCtl.wake && !resetSrc && slpMode_q != SLP_POWER_DOWN && !slpBodOff_q)
      |=> state_q == ST_RUN)
    else $error("idle or standby wake was delayed");

  chk_reset_defaults: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(internalRst_n) |=> ##1 selReg_q == SEL_RC8M && divReg_q == DIV_RESET && activeDiv_q == DIV_RESET)
    else $error("clock defaults not restored by reset");

  chk_unlock_open: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sUnlockWrite |=> unlockCnt_q == UNLOCK_WINDOW)
    else $error("unlock signature did not open window");

  chk_locked_ignore: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sLockedWrite ##0 !inReset |=> $stable(selReg_q) && $stable(divReg_q))
    else $error("protected register changed without unlock");

  chk_div_boundary: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ($changed(activeDiv_q) && !$past(inReset)) |-> $past(sysTick))
    else $error("divider switched mid period");

  chk_trim_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == ST_OSC && state_d == ST_CONFIG) |=> trim_q == $past(factoryTrim))
    else $error("factory trim not loaded");

endmodule // csp_clock_ctrl

// *** verilog/csp_pkg.sv ***
// Constants, types and register map of the clock start-up and prescaler block
package csp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SYS_CLOCK_DIVIDER_REG = 6'h36;
  localparam logic [5:0] IDX_MAIN_CLOCK_SOURCE_REG = 6'h37;
  localparam logic [5:0] IDX_OSC_TRIM_REG          = 6'h39;
  localparam logic [5:0] IDX_STARTUP_STATUS_REG    = 6'h3A;
  localparam logic [5:0] IDX_CONFIG_CHANGE_PROTECT = 6'h3C;
  localparam int         APB_ADDR_W                = 8;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int         SEL_W           = 2;
  localparam int         DIV_W           = 4;
  localparam int         TRIM_W          = 8;
  localparam logic [1:0] SEL_RC8M        = 2'h0;
  localparam logic [1:0] SEL_LP128K      = 2'h1;
  localparam logic [1:0] SEL_EXT         = 2'h2;
  localparam logic [1:0] SEL_RESERVED    = 2'h3;
  localparam logic [3:0] DIV_RESET       = 4'h3;
  localparam logic [3:0] DIV_MAX_CODE    = 4'h8;
  localparam logic [7:0] TRIM_RESET      = 8'h00;
  localparam logic [7:0] UNLOCK_SIG_DFLT = 8'hA5;
  localparam logic [2:0] UNLOCK_WINDOW   = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RST_DELAY_MS     = 64;
  localparam int RST_DELAY_BOD_MS = 128;
  localparam int LP_OSC_KHZ       = 128;
  localparam int RST_DELAY_TICKS  = RST_DELAY_MS * LP_OSC_KHZ;
  localparam int RST_BOD_TICKS    = RST_DELAY_BOD_MS * LP_OSC_KHZ;
  localparam int OSC_START_CYC    = 6;
  localparam int CONFIG_CYC       = 21;
  localparam int CLK_PERIOD_NS    = 20;
  localparam int BOD_WAKE_NS      = 60000;
  localparam int BOD_WAKE_CYC     = BOD_WAKE_NS / CLK_PERIOD_NS;
  localparam int CNT_W            = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLP_IDLE, SLP_ADC_NR, SLP_POWER_DOWN, SLP_STANDBY
  } csp_sleep_mode_t;

  typedef struct packed {
    logic            enter;
    logic            wake;
    csp_sleep_mode_t mode;
    logic            bodOff;
  } csp_sleep_t;

  typedef enum logic [2:0] {
    ST_HOLD, ST_DELAY, ST_OSC, ST_CONFIG, ST_RUN, ST_SLEEP, ST_WAKE_OSC, ST_WAKE_BOD
  } csp_state_t;

endpackage

// *** testbench/csp_clock_ctrl_tb.sv ***
// Self-checking bench for the clock start-up and prescaler block
module csp_clock_ctrl_tb
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Stimulus, ticks and design hookup
  // ------------------------------------------------------------
  localparam logic [7:0] A_DIV  = {IDX_SYS_CLOCK_DIVIDER_REG, 2'b00};
  localparam logic [7:0] A_SRC  = {IDX_MAIN_CLOCK_SOURCE_REG, 2'b00};
  localparam logic [7:0] A_TRIM = {IDX_OSC_TRIM_REG, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STARTUP_STATUS_REG, 2'b00};
  localparam logic [7:0] A_PROT = {IDX_CONFIG_CHANGE_PROTECT, 2'b00};

  logic              ref_clk     = 1'b0;
  logic              reset_n     = 1'b0;
  logic              psel        = 1'b0;
  logic              penable     = 1'b0;
  logic              pwrite      = 1'b0;
  logic [7:0]        paddr       = 8'h00;
  logic [31:0]       pwdata      = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              rcOscTick   = 1'b0;
  logic              lpOscTick   = 1'b0;
  logic              extClkTick  = 1'b0;
  logic              resetSrc    = 1'b0;
  logic              bodEnable   = 1'b1;
  logic [7:0]        factoryTrim = 8'h5A;
  csp_sleep_t        sleepCtl    = '0;
  logic              internalRst_n;
  logic              mainClkEn;
  logic              sysClkEn;
  logic [7:0]        oscTrim;
  logic [1:0]        activeSource;
  logic [7:0]        tickCnt     = 8'h00;
  logic [31:0]       rd;
  logic              err;
  int                n_fail          = 0;
  int                samples_checked = 0;
  int                n;
  int                p;
  int                q;
  csp_sleep_mode_t   modes[3]    = '{SLP_IDLE, SLP_ADC_NR, SLP_STANDBY};

  always #10 ref_clk = ~ref_clk;

  // Calibrated every 2 cycles, low-power every 8, external every 3
  always @(posedge ref_clk) begin
    tickCnt    <= tickCnt + 8'h01;
    rcOscTick  <= tickCnt[0];
    lpOscTick  <= (tickCnt[2:0] == 3'h7);
    extClkTick <= (tickCnt % 8'h03 == 8'h00);
  end

  csp_clock_ctrl #(.RST_TICKS(8), .RST_BOD_TICKS(16)) u_csp_clock_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rcOscTick(rcOscTick), .lpOscTick(lpOscTick), .extClkTick(extClkTick), .resetSrc(resetSrc),
    .bodEnable(bodEnable), .factoryTrim(factoryTrim), .sleepCtl(sleepCtl),
    .internalRst_n(internalRst_n), .mainClkEn(mainClkEn), .sysClkEn(sysClkEn), .oscTrim(oscTrim),
    .activeSource(activeSource));

  // ------------------------------------------------------------
  // Bus, compare and closing tasks
  // ------------------------------------------------------------
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkRange(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next request never rewrites psel in the same step
    @(posedge ref_clk);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chkVal(rd, exp);
  endtask

  // Unlock signature immediately followed by the protected write
  task automatic prot(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, A_PROT, {24'h0, UNLOCK_SIG_DFLT});
    apb(1'b1, a, d);
  endtask

  task automatic stateChk(input logic [2:0] exp);
    apb(1'b0, A_STAT, 32'h0);
    chkVal({29'h0, rd[9:7]}, {29'h0, exp});
  endtask

  task automatic waitRst();
    n = 0;
    while (internalRst_n !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic countSys(input int c);
    p = 0;
    q = 0;
    repeat (c) begin
      @(posedge ref_clk);
      if (sysClkEn === 1'b1) p++;
      if (mainClkEn === 1'b1) q++;
    end
  endtask

  task automatic sleepWake(input csp_sleep_mode_t m, input logic b, input int gap);
    sleepCtl.mode   <= m;
    sleepCtl.bodOff <= b;
    sleepCtl.enter  <= 1'b1;
    @(posedge ref_clk);
    sleepCtl.enter  <= 1'b0;
    // Skip the pulse launched on the entry edge, still in run
    @(posedge ref_clk);
    countSys(gap);
    sleepCtl.wake   <= 1'b1;
    @(posedge ref_clk);
    sleepCtl.wake   <= 1'b0;
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    waitRst();
    chkRange(n, 450, 506);
    rdChk(A_DIV, 32'h3);
    rdChk(A_SRC, 32'h0);
    rdChk(A_TRIM, 32'h5A);
    chkVal({24'h0, oscTrim}, 32'h5A);
    apb(1'b1, A_DIV, 32'h0);
    rdChk(A_DIV, 32'h3);
    prot(A_DIV, 32'h1);
    apb(1'b1, A_DIV, 32'h2);
    rdChk(A_DIV, 32'h1);
    for (int c = 0; c <= 9; c++) begin
      prot(A_DIV, 32'(c));
      rdChk(A_DIV, (c > 8) ? 32'h8 : 32'(c));
      if (c <= 4) begin
        repeat (100) @(posedge ref_clk);
        countSys(64);
        chkRange(p, 32 >> c, 32 >> c);
      end
    end
    prot(A_DIV, 32'h0);
    repeat (700) @(posedge ref_clk);
    prot(A_SRC, 32'h1);
    rdChk(A_SRC, 32'h1);
    repeat (40) @(posedge ref_clk);
    chkVal({30'h0, activeSource}, 32'h1);
    countSys(64);
    chkRange(q, 8, 8);
    prot(A_SRC, 32'h3);
    rdChk(A_SRC, 32'h1);
    prot(A_DIV, 32'h3);
    prot(A_SRC, 32'h2);
    repeat (40) @(posedge ref_clk);
    chkVal({30'h0, activeSource}, 32'h2);
    prot(A_SRC, 32'h0);
    repeat (40) @(posedge ref_clk);
    chkVal({30'h0, activeSource}, 32'h0);
    apb(1'b1, A_TRIM, 32'hFF);
    rdChk(A_TRIM, 32'hFF);
    chkVal({24'h0, oscTrim}, 32'hFF);
    apb(1'b0, 8'h00, 32'h0);
    chkVal({31'h0, err}, 32'h1);
    chkVal(rd, 32'h0);
    foreach (modes[i]) begin
      sleepWake(modes[i], 1'b0, 40);
      chkRange(p, 0, 0);
      stateChk(3'h4);
    end
    sleepWake(SLP_POWER_DOWN, 1'b0, 10);
    stateChk(3'h6);
    repeat (30) @(posedge ref_clk);
    stateChk(3'h4);
    sleepWake(SLP_POWER_DOWN, 1'b1, 10);
    repeat (200) @(posedge ref_clk);
    stateChk(3'h7);
    repeat (3000) @(posedge ref_clk);
    stateChk(3'h4);
    sleepWake(SLP_STANDBY, 1'b1, 10);
    stateChk(3'h7);
    repeat (3000) @(posedge ref_clk);
    stateChk(3'h4);
    resetSrc <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chkVal({31'h0, internalRst_n}, 32'h0);
    resetSrc <= 1'b0;
    waitRst();
    chkRange(n, 386, 442);
    rdChk(A_DIV, 32'h3);
    rdChk(A_TRIM, 32'h5A);
    print_verdict();
  end

endmodule // csp_clock_ctrl_tb
